/* File: design/sbr_bit_timer.sv */
// Times the low and high phases of each falling-edge-to-falling-edge period.
// Assumes line_s is already synchronised to ref_clk.
`timescale 1ns/10ps
`include "sbr_consts.svh"

module sbr_bit_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Synchronised control line
  input wire logic line_s,
  // Events and decoded bit
  output logic fall,
  output logic bit_pulse,
  output sbr_pkg::sbr_bit_t bit_res,
  output logic low_long,
  output logic high_long,
  output logic [`SBR_CNT_W-1:0] low_cnt
);
  import sbr_pkg::*;

  localparam logic [`SBR_CNT_W-1:0] CNT_MAX = {`SBR_CNT_W{1'b1}};
  localparam logic [`SBR_CNT_W-1:0] EOS_LAST = `SBR_CNT_W'(`SBR_EOS_CYC - 1);
  localparam logic [`SBR_CNT_W-1:0] START_LAST = `SBR_CNT_W'(`SBR_START_CYC - 1);

  logic prev_q;
  logic open_q;
  logic [`SBR_CNT_W-1:0] low_q;
  logic [`SBR_CNT_W-1:0] high_q;

  // --------------------------------------------------------------------------
  // Edge and phase counters
  // --------------------------------------------------------------------------
  assign fall = prev_q & ~line_s;
  assign low_long = ~line_s && (low_q == EOS_LAST);
  assign high_long = line_s && (high_q == START_LAST);
  assign bit_pulse = fall & open_q;
  assign bit_res = sbr_decode(low_q, high_q);
  assign low_cnt = low_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= line_s;
    end
  end

  // Counters saturate so a long idle never aliases into a short phase.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      low_q <= '0;
      high_q <= '0;
    end else if (fall) begin
      low_q <= '0;
      high_q <= '0;
    end else if (!line_s) begin
      low_q <= (low_q == CNT_MAX) ? low_q : low_q + 1'b1;
    end else begin
      high_q <= (high_q == CNT_MAX) ? high_q : high_q + 1'b1;
    end
  end

  // A long low or high closes the period so the next edge only opens one.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      open_q <= 1'b0;
    end else if (fall) begin
      open_q <= 1'b1;
    end else if (low_long || high_long) begin
      open_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_period_edges: assert property (@(posedge ref_clk) disable iff (!rstn)
    bit_pulse |-> $past(line_s) && !line_s && open_q)
    else $error("bit reported without a closing falling edge");

  a_ratio_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    bit_pulse && ({2'b00, low_q} >= {1'b0, high_q, 1'b0}) |-> bit_res.ok && !bit_res.value)
    else $error("long low phase not decoded as zero");

  a_ratio_one: assert property (@(posedge ref_clk) disable iff (!rstn)
    bit_pulse && ({2'b00, high_q} >= {1'b0, low_q, 1'b0}) && (low_q != '0)
      |-> bit_res.ok && bit_res.value)
    else $error("long high phase not decoded as one");

endmodule

/* File: design/sbr_consts.svh */
// Timing, width and field constants for the single-wire brightness receiver.
// Assumes a 100 MHz reference clock; cycle counts derive from the times here.
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and link times
// ----------------------------------------------------------------------------
`define SBR_CLK_NS 10
`define SBR_T_START_NS 3500
`define SBR_BYTE_CLOSE_TIME_NS 3500
`define SBR_ACK_VALID_DELAY_NS 3500
`define SBR_ACK_PULSE_TIME_NS 900000

// Least times round up, the longest time rounds down.
`define SBR_START_CYC ((`SBR_T_START_NS + `SBR_CLK_NS - 1) / `SBR_CLK_NS)
`define SBR_EOS_CYC ((`SBR_BYTE_CLOSE_TIME_NS + `SBR_CLK_NS - 1) / `SBR_CLK_NS)
`define SBR_VALACK_CYC ((`SBR_ACK_VALID_DELAY_NS + `SBR_CLK_NS - 1) / `SBR_CLK_NS)
`define SBR_ACKN_CYC (`SBR_ACK_PULSE_TIME_NS / `SBR_CLK_NS)

// ----------------------------------------------------------------------------
// Widths, ratios and fields
// ----------------------------------------------------------------------------
`define SBR_CNT_W 16
`define SBR_ACK_CNT_W 17
`define SBR_RATIO 2
`define SBR_LAST_BIT 4'h7
`define SBR_BIT_CNT_RST 4'h0
`define SBR_LEVEL_W 5
`define SBR_NUM_LEVELS 32
`define SBR_SEL_RST 32'h80000000
`define SBR_SUBADDR_OK 2'h0
`define SBR_CMD_RST 8'h00

`endif

/* File: design/sbr_pkg.sv */
// Types and shared decode for the single-wire brightness receiver.
// Assumes sbr_consts.svh is on the include path.
`include "sbr_consts.svh"

package sbr_pkg;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ack_request_bit;
    logic [1:0] subaddr;
    logic [`SBR_LEVEL_W-1:0] level;
  } sbr_cmd_t;

  typedef struct packed {
    logic ok;
    logic value;
  } sbr_bit_t;

  typedef enum logic [3:0] {
    SBR_IDLE,
    SBR_ADDR_BITS,
    SBR_ADDR_EOS,
    SBR_DATA_START,
    SBR_DATA_BITS,
    SBR_DATA_EOS,
    SBR_ACK_WAIT,
    SBR_ACK_PULSE,
    SBR_ERR_WAIT
  } sbr_state_t;

  // --------------------------------------------------------------------------
  // Ratio decode of one bit period
  // --------------------------------------------------------------------------
  // Widened so the doubled count cannot wrap on a saturated counter.
  function automatic sbr_bit_t sbr_decode(input logic [`SBR_CNT_W-1:0] lo,
                                          input logic [`SBR_CNT_W-1:0] hi);
    sbr_bit_t r;
    logic [`SBR_CNT_W+1:0] lo_w;
    logic [`SBR_CNT_W+1:0] hi_w;
    lo_w = (`SBR_CNT_W+2)'(lo);
    hi_w = (`SBR_CNT_W+2)'(hi);
    r.ok = 1'b0;
    r.value = 1'b0;
    if (lo_w >= hi_w * (`SBR_CNT_W+2)'(`SBR_RATIO)) begin
      r.ok = 1'b1;
    end else if (hi_w >= lo_w * (`SBR_CNT_W+2)'(`SBR_RATIO)) begin
      r.ok = 1'b1;
      r.value = 1'b1;
    end
    return r;
  endfunction

endpackage

/* File: design/sbr_rx.sv */
// Receiver for the one-wire brightness command link with open-drain ack.
// Assumes line_i is the raw pin level, resolved outside with a pull-up.
`timescale 1ns/10ps
`include "sbr_consts.svh"

module sbr_rx #(
  parameter int ACK_CYC = `SBR_ACKN_CYC,
  parameter logic [7:0] DEV_ADDR = 8'h5A // Value is arbitrary.
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control line, open drain
  input wire logic line_i,
  output logic line_o,
  output logic line_oe,
  // Command results
  output sbr_pkg::sbr_cmd_t cmd,
  output logic [`SBR_NUM_LEVELS-1:0] ref_sel,
  output logic cmd_valid,
  output logic rx_error,
  output logic ack_done
);
  import sbr_pkg::*;

  localparam logic [`SBR_CNT_W-1:0] VALACK_CNT = `SBR_CNT_W'(`SBR_VALACK_CYC);
  localparam logic [`SBR_ACK_CNT_W-1:0] ACK_LAST = `SBR_ACK_CNT_W'(ACK_CYC - 1);

  // --------------------------------------------------------------------------
  // Pin synchroniser and bit timer
  // --------------------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic fall;
  logic bit_pulse;
  sbr_bit_t bit_res;
  logic low_long;
  logic high_long;
  logic [`SBR_CNT_W-1:0] low_cnt;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= line_i;
      sync2_q <= sync1_q;
    end
  end

  sbr_bit_timer i_sbr_bit_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .line_s(sync2_q),
    .fall(fall),
    .bit_pulse(bit_pulse),
    .bit_res(bit_res),
    .low_long(low_long),
    .high_long(high_long),
    .low_cnt(low_cnt)
  );

  // --------------------------------------------------------------------------
  // Protocol state
  // --------------------------------------------------------------------------
  sbr_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] next_byte;
  logic addr_match_q;
  logic [`SBR_ACK_CNT_W-1:0] ack_cnt_q;
  logic line_oe_q;
  logic line_o_q;
  sbr_cmd_t cmd_q;
  logic [`SBR_NUM_LEVELS-1:0] ref_sel_q;
  logic cmd_valid_q;
  logic rx_error_q;
  logic ack_done_q;
  logic byte_end;
  logic bad_bit;
  sbr_cmd_t rx_cmd;

  assign next_byte = {shift_q[6:0], bit_res.value};
  assign byte_end = bit_pulse && bit_res.ok && (bit_cnt_q == `SBR_LAST_BIT);
  assign bad_bit = bit_pulse && !bit_res.ok;
  assign rx_cmd = sbr_cmd_t'(shift_q);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= SBR_IDLE;
    end else begin
      unique case (state_q)
        SBR_IDLE: begin
          if (fall) begin
            state_q <= SBR_ADDR_BITS;
          end
        end
        SBR_ADDR_BITS, SBR_DATA_BITS: begin
          if (bad_bit || low_long || high_long) begin
            state_q <= SBR_ERR_WAIT;
          end else if (byte_end) begin
            state_q <= (state_q == SBR_ADDR_BITS) ? SBR_ADDR_EOS : SBR_DATA_EOS;
          end
        end
        SBR_ADDR_EOS: begin
          if (fall || high_long) begin
            state_q <= SBR_ERR_WAIT;
          end else if (low_long) begin
            state_q <= SBR_DATA_START;
          end
        end
        SBR_DATA_START: begin
          if (fall) begin
            state_q <= SBR_ERR_WAIT;
          end else if (high_long) begin
            state_q <= SBR_DATA_BITS;
          end
        end
        SBR_DATA_EOS: begin
          if (fall || high_long) begin
            state_q <= SBR_ERR_WAIT;
          end else if (low_long) begin
            state_q <= (addr_match_q && rx_cmd.ack_request_bit) ? SBR_ACK_WAIT : SBR_IDLE;
          end
        end
        SBR_ACK_WAIT: begin
          if (high_long) begin
            state_q <= SBR_IDLE;
          end else if (!sync2_q && low_cnt >= VALACK_CNT) begin
            state_q <= SBR_ACK_PULSE;
          end
        end
        SBR_ACK_PULSE: begin
          if (ack_cnt_q == ACK_LAST) begin
            state_q <= SBR_IDLE;
          end
        end
        SBR_ERR_WAIT: begin
          if (high_long) begin
            state_q <= SBR_IDLE;
          end
        end
        default: begin
          state_q <= SBR_IDLE;
        end
      endcase
    end
  end

  // Shift register and bit counter; bits enter at the bottom, MSB first.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      shift_q <= `SBR_CMD_RST;
      bit_cnt_q <= `SBR_BIT_CNT_RST;
    end else if (state_q == SBR_IDLE || state_q == SBR_DATA_START) begin
      bit_cnt_q <= `SBR_BIT_CNT_RST;
    end else if (bit_pulse && bit_res.ok) begin
      shift_q <= next_byte;
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      addr_match_q <= 1'b0;
    end else if (state_q == SBR_IDLE) begin
      addr_match_q <= 1'b0;
    end else if (state_q == SBR_ADDR_BITS && byte_end) begin
      addr_match_q <= (next_byte == DEV_ADDR);
    end
  end

  // --------------------------------------------------------------------------
  // Command apply
  // --------------------------------------------------------------------------
  // A non-zero sub-address is taken as meant for another function: not applied, but still acknowledged.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmd_q <= sbr_cmd_t'(`SBR_CMD_RST);
      ref_sel_q <= `SBR_SEL_RST;
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      if (state_q == SBR_DATA_EOS && low_long && addr_match_q) begin
        if (rx_cmd.subaddr == `SBR_SUBADDR_OK) begin
          cmd_q <= rx_cmd;
          ref_sel_q <= `SBR_NUM_LEVELS'(1) << rx_cmd.level;
          cmd_valid_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_error_q <= 1'b0;
    end else begin
      rx_error_q <= (state_q != SBR_ERR_WAIT) && (state_q != SBR_IDLE)
                    && (state_q != SBR_ACK_WAIT) && (state_q != SBR_ACK_PULSE)
                    && ((bad_bit || high_long || low_long) && !byte_end)
                    && !((state_q == SBR_ADDR_EOS || state_q == SBR_DATA_EOS) && low_long)
                    && !(state_q == SBR_DATA_START && high_long)
                    || (fall && (state_q == SBR_ADDR_EOS || state_q == SBR_DATA_EOS
                                 || state_q == SBR_DATA_START));
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge pull-down
  // --------------------------------------------------------------------------
  // The pin only ever sinks; the pull-up on the line supplies the high level.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      line_oe_q <= 1'b0;
      line_o_q <= 1'b0;
      ack_cnt_q <= '0;
      ack_done_q <= 1'b0;
    end else begin
      line_o_q <= 1'b0;
      ack_done_q <= 1'b0;
      if (state_q == SBR_ACK_WAIT && !high_long && !sync2_q && low_cnt >= VALACK_CNT) begin
        line_oe_q <= 1'b1;
        ack_cnt_q <= '0;
      end else if (state_q == SBR_ACK_PULSE) begin
        ack_cnt_q <= ack_cnt_q + 1'b1;
        if (ack_cnt_q == ACK_LAST) begin
          line_oe_q <= 1'b0;
          ack_done_q <= 1'b1;
        end
      end
    end
  end

  assign line_o = line_o_q;
  assign line_oe = line_oe_q;
  assign cmd = cmd_q;
  assign ref_sel = ref_sel_q;
  assign cmd_valid = cmd_valid_q;
  assign rx_error = rx_error_q;
  assign ack_done = ack_done_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_ack_start;
    $rose(line_oe_q);
  endsequence

  sequence s_ack_hold;
    line_oe_q [*8];
  endsequence

  a_ack_cause: assert property (s_ack_start |-> addr_match_q && rx_cmd.ack_request_bit)
    else $error("acknowledge driven without request and address match");

  a_ack_delay: assert property (s_ack_start |-> $past(low_cnt) >= VALACK_CNT)
    else $error("acknowledge started before the valid delay");

  a_ack_hold: assert property (s_ack_start |-> s_ack_hold)
    else $error("acknowledge pulse ended too early");

  a_ack_bound: assert property (line_oe_q |-> ack_cnt_q <= ACK_LAST)
    else $error("acknowledge pulse exceeded its longest time");

  a_ack_release: assert property ($fell(line_oe_q)
      |-> $past(ack_cnt_q) == ACK_LAST && ack_done_q)
    else $error("acknowledge released at the wrong count");

  a_od_low: assert property (line_o_q == 1'b0)
    else $error("open-drain pin drives a high level");

  a_apply_match: assert property ($rose(cmd_valid_q) |-> $past(addr_match_q))
    else $error("command applied without address match");

  a_byte_close: assert property ($rose(cmd_valid_q) |-> $past(low_long, 1))
    else $error("command applied before the byte was closed");

  a_msb_first: assert property (bit_pulse && bit_res.ok && state_q == SBR_ADDR_BITS
      |=> shift_q[0] == $past(bit_res.value) && shift_q[7:1] == $past(shift_q[6:0]))
    else $error("received bit not shifted in MSB first");

  a_sel_onehot: assert property ($onehot(ref_sel_q))
    else $error("reference select not one-hot");

  a_sel_level: assert property (cmd_valid_q |-> ref_sel_q[cmd_q.level])
    else $error("reference select not matching level code");

  a_bad_no_ack: assert property (bad_bit |=> !line_oe_q [*3])
    else $error("acknowledge after a reception error");

endmodule

/* File: verification/sbr_host_model.sv */
// Host side of the one-wire brightness link, pulling the wire low open-drain.
// Assumes the bench resolves the wire with a pull-up and feeds it back as line.
`timescale 1ns/10ps

module sbr_host_model (
  // Clock
  input wire logic ref_clk,
  // Resolved wire and own pull-down
  input wire logic line,
  output logic drive_low,
  output logic ack_seen
);
  localparam int T_GAP = 400;
  // The device checks the line is still low one cycle after its valid delay, behind two
  // synchroniser stages, so the closing low must outlast that by a few cycles.
  localparam int T_CLOSE = 356;
  localparam int T_SHORT = 4;
  localparam int T_LONG = 12;

  initial begin
    drive_low = 1'b0;
    ack_seen = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Link timing
  // --------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // A bad bit uses an even split, which neither ratio accepts.
  task automatic send_byte(input logic [7:0] b, input int bad_idx);
    for (int i = 7; i >= 0; i--) begin
      drive_low = 1'b1;
      if (i == bad_idx) begin
        step(8);
        drive_low = 1'b0;
        step(8);
      end else begin
        step(b[i] ? T_SHORT : T_LONG);
        drive_low = 1'b0;
        step(b[i] ? T_LONG : T_SHORT);
      end
    end
    drive_low = 1'b1;
    step(T_CLOSE);
    // Released after T_CLOSE; on an acknowledged data byte the device pull-down is on by then, so the wire never floats high between.
    drive_low = 1'b0;
  endtask

  task automatic send_frame(input logic [7:0] addr, input logic [7:0] data,
                            input int bad_idx, input logic with_start);
    int n;
    n = 0;
    if (with_start) step(T_GAP);
    send_byte(addr, -1);
    step(T_GAP);
    send_byte(data, bad_idx);
    step(8);
    ack_seen = !line;
    while (!line && n < 5000) begin
      step(1);
      n++;
    end
  endtask
endmodule

/* File: verification/test_sbr_rx.sv */
// Self-checking bench for the single-wire brightness receiver.
// Assumes the design files and sbr_consts.svh are compiled first.
`timescale 1ns/10ps
`include "sbr_consts.svh"

module test_sbr_rx;
  import sbr_pkg::*;

  localparam int ACK_LEN = 50;
  localparam logic [7:0] ADDR = 8'h4B; // Value is arbitrary.

  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic line_i;
  logic line_o;
  logic line_oe;
  sbr_cmd_t cmd;
  logic [`SBR_NUM_LEVELS-1:0] ref_sel;
  logic cmd_valid;
  logic rx_error;
  logic ack_done;
  logic host_low;
  logic host_prev = 1'b0;
  logic ack_seen;
  logic [7:0] prev;
  int errors = 0;
  int checked = 0;
  int n_valid = 0;
  int n_err = 0;
  int n_done = 0;
  int oe_len = 0;
  int ack_lat = 0;
  int since_fall = 0;
  int v0;
  int e0;
  int d0;

  // Open-drain wire: any pull-down wins, otherwise the pull-up holds it high.
  assign line_i = !(host_low || (line_oe === 1'b1));

  always #5 ref_clk = ~ref_clk;

  sbr_rx #(.ACK_CYC(ACK_LEN), .DEV_ADDR(ADDR)) i_sbr_rx (
    .ref_clk(ref_clk), .rstn(rstn), .line_i(line_i), .line_o(line_o), .line_oe(line_oe),
    .cmd(cmd), .ref_sel(ref_sel), .cmd_valid(cmd_valid), .rx_error(rx_error),
    .ack_done(ack_done));

  sbr_host_model i_sbr_host_model (
    .ref_clk(ref_clk), .line(line_i), .drive_low(host_low), .ack_seen(ack_seen));

  // --------------------------------------------------------------------------
  // Event monitor
  // --------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    host_prev <= host_low;
    since_fall <= (host_low && !host_prev) ? 0 : since_fall + 1;
    if (cmd_valid === 1'b1) n_valid <= n_valid + 1;
    if (rx_error === 1'b1) n_err <= n_err + 1;
    if (ack_done === 1'b1) n_done <= n_done + 1;
    if (line_oe === 1'b1) begin
      oe_len <= oe_len + 1;
      if (oe_len == 0) ack_lat <= since_fall;
    end
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [7:0] a, input logic [7:0] d, input int bad,
                       input logic gap);
    v0 = n_valid;
    e0 = n_err;
    d0 = n_done;
    oe_len = 0;
    prev = cmd;
    i_sbr_host_model.send_frame(a, d, bad, gap);
    check(line_i, 1'b1);
    if (line_i !== 1'b1) final_report();
    repeat (100) @(posedge ref_clk);
    #1;
  endtask

  task automatic applied(input logic [4:0] code);
    check(n_valid - v0, 1);
    check(cmd, {3'h0, code});
    check(ref_sel, 32'h1 << code);
    check(n_done - d0, 0);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    check(cmd, 32'h0);
    check(ref_sel, 32'h80000000);
    check(line_oe, 1'b0);
    check(line_o, 1'b0);
  endtask

  // The wire has stayed high since reset, so no start interval is sent.
  task automatic t_first();
    frame(ADDR, 8'h15, -1, 1'b0);
    applied(5'h15);
  endtask

  task automatic t_levels();
    logic [4:0] codes [3];
    codes = '{5'h00, 5'h1F, 5'h0A};
    foreach (codes[i]) begin
      frame(ADDR, {3'h0, codes[i]}, -1, 1'b1);
      applied(codes[i]);
    end
  endtask

  task automatic t_ack();
    frame(ADDR, 8'h87, -1, 1'b1);
    check(n_valid - v0, 1);
    check(cmd, 8'h87);
    check(n_done - d0, 1);
    check(oe_len, ACK_LEN);
    check(ack_lat >= 349 && ack_lat <= 360, 1'b1);
    check(ack_seen, 1'b1);
    check(line_o, 1'b0);
  endtask

  // One address differs in its last bit, the other is ours sent bit-reversed.
  task automatic t_wrong_addr();
    logic [7:0] bad_addr [2];
    bad_addr = '{ADDR ^ 8'h01, 8'hD2};
    foreach (bad_addr[i]) begin
      frame(bad_addr[i], 8'h9F, -1, 1'b1);
      check(n_valid - v0, 0);
      check(cmd, prev);
      check(n_done - d0, 0);
      check(oe_len, 0);
      check(n_err - e0, 0);
    end
  endtask

  task automatic t_bad_bit();
    frame(ADDR, 8'h9F, 2, 1'b1);
    check(n_err - e0 > 0, 1'b1);
    check(n_valid - v0, 0);
    check(n_done - d0, 0);
    check(ack_seen, 1'b0);
  endtask

  task automatic t_subaddr();
    frame(ADDR, 8'hC3, -1, 1'b1);
    check(n_valid - v0, 0);
    check(cmd, prev);
    check(n_done - d0, 1);
    check(oe_len, ACK_LEN);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_first();
    t_levels();
    t_ack();
    t_wrong_addr();
    t_bad_bit();
    t_subaddr();
    final_report();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule
